// ===== ilc_top.sv
// Two-level interrupt controller with vectored and macro-service handling.
`timescale 1ns/1ns
module ilc_top
  import ilc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic [NUM_PIN-1:0] ext_pin_req,
  input  wire logic               nmi_pin,
  input  wire ilc_periph_req_type periph_req,
  input  wire ilc_src_ctl_type    src_ctl,
  input  wire logic               int_enable,
  input  wire logic               software_break,
  input  wire logic               cpu_ack,
  input  wire logic               cpu_reti,
  input  wire logic               macro_done,
  output ilc_cmd_type             cmd_r,
  output logic                    restore_ctx_r,
  output logic [2:0]              in_service_r,
  output logic [NUM_SRC-1:0]      pending_r,
  output ilc_trig_type            trig_r
);

  // ----------------------------------------------------------------
  // Reset release and pin edges
  // ----------------------------------------------------------------
  logic               rst_meta_r;
  logic               rst_n_r;
  logic [NUM_PIN-1:0] pin_edge;
  logic               nmi_edge;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  for (genvar g = 0; g < NUM_PIN; g++)
  begin : g_pin
    ilc_edge u_edge (
      .clk    (clk),
      .rst_n  (rst_n_r),
      .pin    (ext_pin_req[g]),
      .edge_r (pin_edge[g])
    );
  end

  ilc_edge u_nmi_edge (
    .clk    (clk),
    .rst_n  (rst_n_r),
    .pin    (nmi_pin),
    .edge_r (nmi_edge)
  );

  // ----------------------------------------------------------------
  // Source mapping in default order
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] src_set;

  always_comb
  begin
    src_set          = '0;
    src_set[SRC_P0]  = pin_edge[0];
    src_set[SRC_P1]  = pin_edge[1];
    src_set[SRC_P2]  = pin_edge[2];
    src_set[SRC_P3]  = pin_edge[3];
    src_set[SRC_C00] = periph_req.t16_match_a_req;
    src_set[SRC_C01] = periph_req.t16_match_b_req;
    src_set[SRC_C10] = periph_req.t8a_match_a_req;
    src_set[SRC_C11] = periph_req.t8a_match_b_req;
    src_set[SRC_C21] = periph_req.t8b_match_b_req;
    src_set[SRC_P4]  = pin_edge[4];
    src_set[SRC_C30] = periph_req.t8c_match_req;
    src_set[SRC_P5]  = pin_edge[5];
    src_set[SRC_AD]  = periph_req.adc_done_req;
    src_set[SRC_C20] = periph_req.t8b_match_a_req;
    src_set[SRC_SER] = periph_req.uart_rx_error_req;
    src_set[SRC_SR]  = periph_req.uart_rx_done_req;
    src_set[SRC_ST]  = periph_req.uart_tx_done_req;
    src_set[SRC_CSI] = periph_req.sync_serial_done_req;
    src_set[SRC_EER] = periph_req.nvm_write_error_req;
    src_set[SRC_EPW] = periph_req.nvm_write_done_req;
  end

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] elig;
  logic               sel_found;
  logic               sel_high;
  logic [SRC_W-1:0]   sel_idx;
  logic               sel_macro;
  logic               allow_high;
  logic               allow_low;

  always_comb
  begin
    allow_high = int_enable && !in_service_r[ISR_HIGH] && !in_service_r[ISR_NMI];
    allow_low  = int_enable && (in_service_r == 3'h0);
    // Macro requests ignore the service level so they always nest.
    elig = pending_r & ~src_ctl.mask & (src_ctl.macro
           | (src_ctl.high & {NUM_SRC{allow_high}})
           | (~src_ctl.high & {NUM_SRC{allow_low}}));
    sel_found = 1'b0;
    sel_high  = 1'b0;
    sel_idx   = '0;
    // Downward scan leaves the lowest index, the highest default rank.
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig[i] && !src_ctl.high[i] && !sel_high)
      begin
        sel_found = 1'b1;
        sel_idx   = SRC_W'(i);
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig[i] && src_ctl.high[i])
      begin
        sel_found = 1'b1;
        sel_high  = 1'b1;
        sel_idx   = SRC_W'(i);
      end
    end
    sel_macro = src_ctl.macro[sel_idx];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ilc_state_type      state_r;
  ilc_state_type      state_nxt;
  ilc_cmd_type        cmd_nxt;
  logic [NUM_SRC-1:0] pending_nxt;
  logic [NUM_SRC-1:0] clr;
  logic [2:0]         isr_nxt;
  logic               nmi_flag_r;
  logic               nmi_flag_nxt;
  logic               brk_flag_r;
  logic               brk_flag_nxt;
  logic               restore_nxt;
  logic               take_nmi;
  logic               take_brk;
  logic               take_sel;
  ilc_trig_type       trig_nxt;

  always_comb
  begin
    state_nxt   = state_r;
    cmd_nxt     = cmd_r;
    isr_nxt     = in_service_r;
    clr         = '0;
    restore_nxt = 1'b0;
    take_nmi    = 1'b0;
    take_brk    = 1'b0;
    take_sel    = 1'b0;
    nmi_flag_nxt = nmi_flag_r;
    brk_flag_nxt = brk_flag_r;
    unique case (state_r)
      ILC_IDLE:
      begin
        if (nmi_flag_r && !in_service_r[ISR_NMI])
        begin
          take_nmi             = 1'b1;
          nmi_flag_nxt         = 1'b0;
          isr_nxt[ISR_NMI]     = 1'b1;
          cmd_nxt.vec_req      = 1'b1;
          cmd_nxt.save_ctx     = 1'b1;
          cmd_nxt.vec_addr     = VEC_NMI;
          state_nxt            = ILC_VEC;
        end
        else if (brk_flag_r)
        begin
          take_brk             = 1'b1;
          brk_flag_nxt         = 1'b0;
          cmd_nxt.vec_req      = 1'b1;
          cmd_nxt.save_ctx     = 1'b1;
          cmd_nxt.vec_addr     = VEC_BRK;
          state_nxt            = ILC_VEC;
        end
        else if (sel_found)
        begin
          take_sel     = 1'b1;
          clr[sel_idx] = 1'b1;
          if (sel_macro)
          begin
            cmd_nxt.macro_req = 1'b1;
            cmd_nxt.macro_src = sel_idx;
            state_nxt         = ILC_MAC;
          end
          else
          begin
            isr_nxt[sel_high ? ISR_HIGH : ISR_LOW] = 1'b1;
            cmd_nxt.vec_req   = 1'b1;
            cmd_nxt.save_ctx  = 1'b1;
            cmd_nxt.vec_addr  = VEC_TABLE[sel_idx];
            state_nxt         = ILC_VEC;
          end
        end
      end
      ILC_VEC:
      begin
        if (cpu_ack)
        begin
          cmd_nxt.vec_req  = 1'b0;
          cmd_nxt.save_ctx = 1'b0;
          state_nxt        = ILC_IDLE;
        end
      end
      ILC_MAC:
      begin
        if (macro_done)
        begin
          cmd_nxt.macro_req = 1'b0;
          state_nxt         = ILC_IDLE;
        end
      end
      default:
      begin
        state_nxt = ILC_IDLE;
      end
    endcase
    // The return instruction closes the innermost active level.
    if (cpu_reti)
    begin
      restore_nxt = 1'b1;
      if (in_service_r[ISR_NMI])
        isr_nxt[ISR_NMI] = 1'b0;
      else if (in_service_r[ISR_HIGH])
        isr_nxt[ISR_HIGH] = 1'b0;
      else
        isr_nxt[ISR_LOW] = 1'b0;
    end
    // A new event in the clearing cycle keeps its flag.
    pending_nxt = (pending_r & ~clr) | src_set;
    nmi_flag_nxt = nmi_flag_nxt | nmi_edge;
    brk_flag_nxt = brk_flag_nxt | software_break;
    trig_nxt.timer8_a_capture = pin_edge[0];
    trig_nxt.timer8_b_capture = pin_edge[1];
    trig_nxt.timer8_b_count   = pin_edge[2];
    trig_nxt.timer16_capture  = pin_edge[3];
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r       <= ILC_IDLE;
      cmd_r         <= '0;
      in_service_r  <= 3'h0;
      pending_r     <= '0;
      nmi_flag_r    <= 1'b0;
      brk_flag_r    <= 1'b0;
      restore_ctx_r <= 1'b0;
      trig_r        <= '0;
    end
    else
    begin
      state_r       <= state_nxt;
      cmd_r         <= cmd_nxt;
      in_service_r  <= isr_nxt;
      pending_r     <= pending_nxt;
      nmi_flag_r    <= nmi_flag_nxt;
      brk_flag_r    <= brk_flag_nxt;
      restore_ctx_r <= restore_nxt;
      trig_r        <= trig_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] same_lvl;
  assign same_lvl = sel_high ? src_ctl.high : ~src_ctl.high;

  nmi_grant_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    (take_nmi && state_r == ILC_IDLE && nmi_flag_r && !in_service_r[ISR_NMI])
      |=> (cmd_r.vec_req && cmd_r.vec_addr == VEC_NMI && in_service_r[ISR_NMI]))
    else $error("Nonmaskable request not branched to its vector.");

  brk_grant_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    take_brk |=> (cmd_r.vec_req && cmd_r.save_ctx && cmd_r.vec_addr == VEC_BRK))
    else $error("Software break not branched to its vector.");

  vec_hold_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    (cmd_r.vec_req && !cpu_ack) |=> (cmd_r.vec_req && $stable(cmd_r.vec_addr)))
    else $error("Vector request dropped before acknowledge.");

  save_ctx_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    $rose(cmd_r.vec_req) |-> cmd_r.save_ctx)
    else $error("Vectored branch without context save.");

  macro_ctx_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    cmd_r.macro_req |-> !cmd_r.save_ctx && !cmd_r.vec_req)
    else $error("Macro service touched CPU context.");

  reti_restore_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    cpu_reti |=> restore_ctx_r ##1 !restore_ctx_r || $past(cpu_reti))
    else $error("Return did not restore context.");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    (take_sel && !src_set[sel_idx]) |=> !pending_r[$past(sel_idx)])
    else $error("Request flag not cleared on acknowledge.");

  nest_level_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    (take_sel && !sel_macro)
      |-> (sel_high ? (!in_service_r[ISR_HIGH] && !in_service_r[ISR_NMI])
                    : in_service_r == 3'h0))
    else $error("Request accepted at or below service level.");

  default_order_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    take_sel |-> ((elig & same_lvl & ((NUM_SRC'(1) << sel_idx) - NUM_SRC'(1))) == '0))
    else $error("Default order not respected.");

  pin_trig_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    pin_edge[0] |=> trig_r.timer8_a_capture && pending_r[SRC_P0])
    else $error("Pin 0 edge lost its capture trigger or flag.");

endmodule

// ===== ilc_pkg.sv
// Package of constants and carrier types for the two-level interrupt controller.
package ilc_pkg;

  localparam int NUM_SRC = 20;
  localparam int NUM_PIN = 6;
  localparam int SRC_W   = 5;

  // Source indices in fixed default order, index 0 ranks highest.
  localparam int SRC_P0  = 0;
  localparam int SRC_P1  = 1;
  localparam int SRC_P2  = 2;
  localparam int SRC_P3  = 3;
  localparam int SRC_C00 = 4;
  localparam int SRC_C01 = 5;
  localparam int SRC_C10 = 6;
  localparam int SRC_C11 = 7;
  localparam int SRC_C21 = 8;
  localparam int SRC_P4  = 9;
  localparam int SRC_C30 = 10;
  localparam int SRC_P5  = 11;
  localparam int SRC_AD  = 12;
  localparam int SRC_C20 = 13;
  localparam int SRC_SER = 14;
  localparam int SRC_SR  = 15;
  localparam int SRC_ST  = 16;
  localparam int SRC_CSI = 17;
  localparam int SRC_EER = 18;
  localparam int SRC_EPW = 19;

  // In-service bit positions.
  localparam int ISR_LOW  = 0;
  localparam int ISR_HIGH = 1;
  localparam int ISR_NMI  = 2;

  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_BRK = 16'h003E;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h0014, 16'h0016, 16'h0018,
    16'h001A, 16'h001C, 16'h000E, 16'h000E, 16'h0010, 16'h0010, 16'h0012,
    16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h002A};

  typedef enum logic [1:0] {
    ILC_IDLE = 2'b00,
    ILC_VEC  = 2'b01,
    ILC_MAC  = 2'b11
  } ilc_state_type;

  // Per-source programming, one bit per source index.
  typedef struct packed {
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] high;
    logic [NUM_SRC-1:0] macro;
  } ilc_src_ctl_type;

  // One-cycle event pulses from the internal units.
  typedef struct packed {
    logic t16_match_a_req;
    logic t16_match_b_req;
    logic t8a_match_a_req;
    logic t8a_match_b_req;
    logic t8b_match_a_req;
    logic t8b_match_b_req;
    logic t8c_match_req;
    logic adc_done_req;
    logic uart_rx_error_req;
    logic uart_rx_done_req;
    logic uart_tx_done_req;
    logic sync_serial_done_req;
    logic nvm_write_error_req;
    logic nvm_write_done_req;
  } ilc_periph_req_type;

  // Command to the CPU core.
  typedef struct packed {
    logic             vec_req;
    logic             save_ctx;
    logic [15:0]      vec_addr;
    logic             macro_req;
    logic [SRC_W-1:0] macro_src;
  } ilc_cmd_type;

  // Pin edges passed on to the timers.
  typedef struct packed {
    logic timer8_a_capture;
    logic timer8_b_capture;
    logic timer8_b_count;
    logic timer16_capture;
  } ilc_trig_type;

endpackage

// ===== ilc_edge.sv
// Pin synchroniser with a one-cycle rising edge pulse.
`timescale 1ns/1ns
module ilc_edge
  import ilc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      edge_r
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic edge_nxt;

  always_comb
  begin
    edge_nxt = sync2_r & ~prev_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      edge_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      edge_r  <= edge_nxt;
    end
  end

  pulse_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    edge_r |=> !edge_r)
    else $error("Edge pulse lasted more than one cycle.");

endmodule

// ===== ilc_cpu_model.sv
// Behavioural CPU core that answers vectored and macro-service commands.
`timescale 1ns/1ns
module ilc_cpu_model
  import ilc_pkg::*;
(
  input  wire logic        clk,
  input  wire ilc_cmd_type cmd_r,
  input  wire logic        slow,
  output logic             cpu_ack,
  output logic             macro_done
);
  // ---------------------------------------------------------------
  // Command answer
  // ---------------------------------------------------------------
  logic mac;

  // The extra edge after release keeps a dropping command from being answered twice.
  initial
  begin
    cpu_ack    = 1'b0;
    macro_done = 1'b0;
    forever
    begin
      @(posedge clk);
      if (cmd_r.vec_req === 1'b1 || cmd_r.macro_req === 1'b1)
      begin
        mac = cmd_r.macro_req;
        repeat (slow ? 5 : 0) @(posedge clk);
        #2;
        cpu_ack    = ~mac;
        macro_done = mac;
        @(posedge clk);
        #2;
        cpu_ack    = 1'b0;
        macro_done = 1'b0;
        @(posedge clk);
      end
    end
  end
endmodule

// ===== ilc_top_tb.sv
// Self-checking testbench for the two-level interrupt controller.
`timescale 1ns/1ns
module ilc_top_tb
  import ilc_pkg::*;
;
  localparam int PIDX [14] = '{4, 5, 6, 7, 13, 8, 10, 12, 14, 15, 16, 17, 18, 19};

  logic               clk            = 1'b0;
  logic               reset_n        = 1'b0;
  logic [NUM_PIN-1:0] ext_pin_req    = '0;
  logic               nmi_pin        = 1'b0;
  ilc_periph_req_type periph_req     = '0;
  ilc_src_ctl_type    src_ctl        = '0;
  logic               int_enable     = 1'b0;
  logic               software_break = 1'b0;
  logic               cpu_reti       = 1'b0;
  logic               slow           = 1'b0;
  logic               cpu_ack;
  logic               macro_done;
  ilc_cmd_type        cmd_r;
  logic               restore_ctx_r;
  logic [2:0]         in_service_r;
  logic [NUM_SRC-1:0] pending_r;
  ilc_trig_type       trig_r;
  logic [16:0]        exp_q [$];
  logic [16:0]        exp_v;
  logic               prev_vec   = 1'b0;
  logic               prev_mac   = 1'b0;
  int                 grants     = 0;
  int                 want       = 0;
  int                 fail_count = 0;
  int                 n_tests    = 0;
  int                 seed_v;
  int                 n;

  always #10 clk = ~clk;

  ilc_top u_ilc_top (
    .clk            (clk),
    .reset_n        (reset_n),
    .ext_pin_req    (ext_pin_req),
    .nmi_pin        (nmi_pin),
    .periph_req     (periph_req),
    .src_ctl        (src_ctl),
    .int_enable     (int_enable),
    .software_break (software_break),
    .cpu_ack        (cpu_ack),
    .cpu_reti       (cpu_reti),
    .macro_done     (macro_done),
    .cmd_r          (cmd_r),
    .restore_ctx_r  (restore_ctx_r),
    .in_service_r   (in_service_r),
    .pending_r      (pending_r),
    .trig_r         (trig_r)
  );

  ilc_cpu_model u_ilc_cpu_model (
    .clk        (clk),
    .cmd_r      (cmd_r),
    .slow       (slow),
    .cpu_ack    (cpu_ack),
    .macro_done (macro_done)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  function automatic logic [NUM_SRC-1:0] bit_of(input int s);
    return 20'h00001 << s;
  endfunction

  // Pulses the internal units whose source bits are set.
  task automatic pulse(input logic [NUM_SRC-1:0] srcs);
    for (int k = 0; k < 14; k++)
      if (srcs[PIDX[k]])
        periph_req[13-k] = 1'b1;
    tick(1);
    periph_req = '0;
    tick(1);
  endtask

  // Waits for the next granted command and for it to be answered.
  task automatic wait_cmd();
    int w;
    w = 0;
    want++;
    while (grants < want && w < 60)
    begin
      tick(1);
      w++;
    end
    while ((cmd_r.vec_req === 1'b1 || cmd_r.macro_req === 1'b1) && w < 120)
    begin
      tick(1);
      w++;
    end
    check(w < 60, 1'b1);
  endtask

  task automatic reti(input logic [2:0] is_exp, input bit chk);
    int w;
    w = 0;
    cpu_reti = 1'b1;
    tick(1);
    cpu_reti = 1'b0;
    while (restore_ctx_r !== 1'b1 && w < 4)
    begin
      tick(1);
      w++;
    end
    check(w < 4, 1'b1);
    tick(1);
    check(restore_ctx_r, 1'b0);
    if (chk)
      check(in_service_r, is_exp);
  endtask

  // ---------------------------------------------------------------
  // Grant monitor
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if ((cmd_r.vec_req === 1'b1 && !prev_vec) || (cmd_r.macro_req === 1'b1 && !prev_mac))
    begin
      grants++;
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1FFFF;
      check({cmd_r.macro_req, cmd_r.macro_req ? {11'h000, cmd_r.macro_src} : cmd_r.vec_addr},
            exp_v);
      check(cmd_r.save_ctx, !cmd_r.macro_req);
    end
    prev_vec <= (cmd_r.vec_req === 1'b1);
    prev_mac <= (cmd_r.macro_req === 1'b1);
  end

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed_v = $urandom(32'hE15AA6C7);
    repeat (6) @(posedge clk);
    #2;
    reset_n = 1'b1;
    tick(5);
    // Every source at once, all low level, served in fixed order.
    ext_pin_req = '1;
    n = 0;
    while (trig_r === 4'h0 && n < 10)
    begin
      tick(1);
      n++;
    end
    check(trig_r, 4'hF);
    tick(1);
    check(trig_r, 4'h0);
    pulse('1);
    tick(2);
    check(pending_r, 20'hFFFFF);
    for (int i = 0; i < NUM_SRC; i++)
      exp_q.push_back({1'b0, VEC_TABLE[i]});
    int_enable = 1'b1;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      slow = $urandom_range(1, 0);
      wait_cmd();
      check(in_service_r, 3'b001);
      reti(3'b000, 0);
    end
    tick(3);
    check(pending_r, 20'h00000);
    // A high level wins over a lower default rank, then nesting.
    src_ctl.high[SRC_AD] = 1'b1;
    exp_q.push_back({1'b0, VEC_TABLE[SRC_AD]});
    exp_q.push_back({1'b0, VEC_TABLE[SRC_C00]});
    pulse(bit_of(SRC_AD) | bit_of(SRC_C00));
    wait_cmd();
    check(in_service_r, 3'b010);
    reti(3'b000, 0);
    wait_cmd();
    exp_q.push_back({1'b0, VEC_TABLE[SRC_AD]});
    pulse(bit_of(SRC_AD));
    wait_cmd();
    check(in_service_r, 3'b011);
    pulse(bit_of(SRC_C01));
    reti(3'b001, 1);
    tick(5);
    check(pending_r[SRC_C01], 1'b1);
    exp_q.push_back({1'b0, VEC_TABLE[SRC_C01]});
    reti(3'b000, 0);
    wait_cmd();
    reti(3'b000, 1);
    // A masked source waits until unmasked.
    src_ctl.mask[SRC_C10] = 1'b1;
    pulse(bit_of(SRC_C10));
    tick(10);
    check(pending_r[SRC_C10], 1'b1);
    exp_q.push_back({1'b0, VEC_TABLE[SRC_C10]});
    src_ctl.mask[SRC_C10] = 1'b0;
    wait_cmd();
    reti(3'b000, 1);
    // Macro service nests inside a low-level routine.
    src_ctl.macro[SRC_SR] = 1'b1;
    exp_q.push_back({1'b0, VEC_TABLE[SRC_C00]});
    pulse(bit_of(SRC_C00));
    wait_cmd();
    exp_q.push_back({1'b1, 11'h000, 5'(SRC_SR)});
    pulse(bit_of(SRC_SR));
    wait_cmd();
    check(in_service_r, 3'b001);
    check(pending_r[SRC_SR], 1'b0);
    reti(3'b000, 1);
    // Nonmaskable edge and software break with everything masked.
    int_enable   = 1'b0;
    src_ctl.mask = '1;
    exp_q.push_back({1'b0, VEC_NMI});
    nmi_pin = 1'b1;
    wait_cmd();
    check(in_service_r, 3'b100);
    reti(3'b000, 1);
    exp_q.push_back({1'b0, VEC_BRK});
    software_break = 1'b1;
    tick(1);
    software_break = 1'b0;
    wait_cmd();
    check(in_service_r, 3'b000);
    tick(5);
    check(exp_q.size(), 0);
    conclude();
  end
endmodule
